// ===== src/serial_word_pkg.sv
// Purpose: shared constants, field layout and BCD helpers for the serial word bus
// Assumes: one 25 MHz clock; bit times are enable pulses from a divider
// Notes:   digit 0 is the least significant digit and is shifted first
package serial_word_pkg;

  // clock and bit timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int BIT_PERIOD_NS  = 200;
  localparam int BIT_DIV_CYCLES = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] BIT_DIV_LAST = 3'(BIT_DIV_CYCLES - 1);

  // word geometry
  localparam int WORD_DIGITS = 14;
  localparam int DIGIT_BITS  = 4;
  localparam int WORD_BITS   = WORD_DIGITS * DIGIT_BITS;
  localparam logic [5:0] WORD_LAST_BIT = 6'(WORD_BITS - 1);
  localparam logic [3:0] LAST_DIGIT    = 4'(WORD_DIGITS - 1);

  // instruction geometry: sent in the first bit times of every word
  localparam int INSTR_BITS = 10;
  localparam logic [5:0] INSTR_LAST_BIT = 6'(INSTR_BITS - 1);
  localparam logic [9:0] INSTR_NOP      = 10'h000;

  // digit positions inside a word
  localparam int EXP_LO_DIGIT    = 0;
  localparam int EXP_DIGITS      = 2;
  localparam int EXP_SIGN_DIGIT  = 2;
  localparam int MANT_LO_DIGIT   = 3;
  localparam int MANT_DIGITS     = 10;
  localparam int MANT_SIGN_DIGIT = 13;

  // sign digit codes; the mantissa sign digit also holds the point position
  localparam logic [3:0] SIGN_POS  = 4'h0;
  localparam logic [3:0] SIGN_NEG  = 4'h9;
  localparam int         MSIGN_BIT = 3;
  localparam int         DP_BITS   = 3;

  // instruction buffer on the sending end
  localparam int IBUF_DEPTH = 2;
  localparam logic [1:0] IBUF_FULL = 2'(IBUF_DEPTH);

  // two-digit BCD ten's complement; applying it twice gives the value back
  function automatic logic [7:0] bcd_tens_comp(input logic [7:0] v);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = 4'h0;
    hi = 4'h0;
    if (v[3:0] != 4'h0) begin
      lo = 4'hA - v[3:0];
      hi = 4'h9 - v[7:4];
    end else if (v[7:4] != 4'h0) begin
      hi = 4'hA - v[7:4];
    end
    return {hi, lo};
  endfunction : bcd_tens_comp

endpackage : serial_word_pkg

// ===== src/serial_word_if.sv
// Purpose: the three shared lines plus data, carry and bit strobe between the two ends
// Assumes: every line is sampled on the cycle in which bit_strobe is high
// Notes:   the word-select gate is a wired OR of the two possible drivers
`timescale 1ns/1ps
interface serial_word_if;
  logic bit_strobe;
  logic word_sync;
  logic dev_ws;
  logic rom_ws;
  logic word_select_gate;
  logic serial_instruction_line;
  logic data_line;
  logic carry_line;
  logic iset_alt;

  // either end may open the gate for its part of the word
  assign word_select_gate = dev_ws | rom_ws;

  modport timing_end (
    output bit_strobe, word_sync, dev_ws, iset_alt,
    input  word_select_gate, serial_instruction_line, data_line, carry_line
  );
  modport source_end (
    output rom_ws, serial_instruction_line, data_line, carry_line,
    input  bit_strobe, word_sync, word_select_gate, iset_alt
  );
endinterface : serial_word_if

// ===== src/ctl_timing_end.sv
// Purpose: timing end of the serial word bus: word counter, sync, gate, carry record
// Assumes: all inputs synchronous to clk_i; the source end follows word_sync
// Notes:   one bit time is BIT_DIV_CYCLES clocks; lines change after each strobe
// Summary of operation
// - word is fourteen BCD digits, 56 bits
// - ten mantissa, mantissa sign, two exponent, sign
// - negative exponent ten's complement, positive plain BCD
// - 56-state counter produces word sync
// - instructions arrive bit-serially on instruction line
// - selected instruction set decides instruction meaning
// - gate driven by timing end or source
// - gate spans whole digits, zero to fourteen
// - point position rides inside mantissa sign digit
// - carry recorded at last bit of each gated run
`timescale 1ns/1ps
module ctl_timing_end
  import serial_word_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  serial_word_if.timing_end bus,
  // word settings, taken at the next word start
  input  wire logic        iset_alt_i,
  input  wire logic        ws_en_i,
  input  wire logic [3:0]  ws_first_i,
  input  wire logic [3:0]  ws_last_i,
  // user side: decoded instruction, carry and word fields
  output logic      [9:0]  instr_pri_o,
  output logic      [9:0]  instr_alt_o,
  output logic             instr_valid_o,
  output logic             carry_o,
  output logic             carry_valid_o,
  output logic      [39:0] mant_o,
  output logic             mant_neg_o,
  output logic      [2:0]  dp_pos_o,
  output logic             exp_neg_o,
  output logic      [7:0]  exp_mag_o,
  output logic             word_valid_o,
  output logic      [5:0]  bit_cnt_o
);

  // all state lives in one packed struct; the comb block edits a copy
  typedef struct packed {
    logic [2:0]  div;
    logic        bit_en;
    logic [5:0]  bit_cnt;
    logic        word_sync;
    logic        iset_alt;
    logic        ws_en;
    logic [3:0]  ws_first;
    logic [3:0]  ws_last;
    logic        dev_ws;
    logic [9:0]  ishift;
    logic [9:0]  instr_pri;
    logic [9:0]  instr_alt;
    logic        instr_valid;
    logic [55:0] dshift;
    logic [39:0] mant;
    logic        mant_neg;
    logic [2:0]  dp_pos;
    logic        exp_neg;
    logic [7:0]  exp_mag;
    logic        word_valid;
    logic        gate_prev;
    logic        carry_cand;
    logic        carry;
    logic        carry_valid;
  } dev_state_s;

  dev_state_s st_q;
  dev_state_s st_d;

  // window test for one digit; first above last gives an empty window
  // digits past 13 never gate, so a stray setting cannot run past the word
  function automatic logic in_window(input logic       en,
                                     input logic [3:0] first,
                                     input logic [3:0] last,
                                     input logic [5:0] bit_idx);
    logic [3:0] dig;
    dig = bit_idx[5:2];
    return en && (dig >= first) && (dig <= last) && (dig <= LAST_DIGIT);
  endfunction : in_window

  // next-state logic; everything on the bus moves only on a bit strobe
  always_comb begin
    logic [5:0]  nxt_bit;
    logic [9:0]  iword;
    logic [55:0] dword;
    logic        gate;
    st_d        = st_q;
    nxt_bit     = 6'h00;
    iword       = {bus.serial_instruction_line, st_q.ishift[9:1]};
    dword       = {bus.data_line, st_q.dshift[55:1]};
    gate        = bus.word_select_gate;
    // pulses last one clock unless set again below
    st_d.bit_en = 1'b0;
    st_d.instr_valid = 1'b0;
    st_d.word_valid  = 1'b0;
    st_d.carry_valid = 1'b0;

    // divider makes the bit-time enable; a slower rate never uses a second clock
    // five clocks per bit give the far end four quiet clocks before each sample
    if (st_q.div == BIT_DIV_LAST) begin
      st_d.div    = 3'h0;
      st_d.bit_en = 1'b1;
    end else begin
      st_d.div = st_q.div + 3'h1;
    end

    if (st_q.bit_en) begin
      // sync covers all of bit 55, so a late joiner cannot miss it
      // wrap after the last bit so the counter has exactly 56 states
      nxt_bit = (st_q.bit_cnt == WORD_LAST_BIT) ? 6'h00 : st_q.bit_cnt + 6'h01;
      st_d.bit_cnt   = nxt_bit;
      st_d.word_sync = (nxt_bit == WORD_LAST_BIT);

      // gate settings are taken only at a word boundary so no window is cut
      if (nxt_bit == 6'h00) begin
        st_d.iset_alt = iset_alt_i;
        st_d.ws_en    = ws_en_i;
        st_d.ws_first = ws_first_i;
        st_d.ws_last  = ws_last_i;
        st_d.dev_ws   = in_window(ws_en_i, ws_first_i, ws_last_i, nxt_bit);
      end else begin
        st_d.dev_ws   = in_window(st_q.ws_en, st_q.ws_first, st_q.ws_last, nxt_bit);
      end

      // instruction bits arrive least significant first in bits 0..9
      // later bits leave the shifter alone, so it holds the last instruction
      if (st_q.bit_cnt <= INSTR_LAST_BIT) begin
        st_d.ishift = iword;
      end
      if (st_q.bit_cnt == INSTR_LAST_BIT) begin
        st_d.instr_valid = 1'b1;
        // the idle set sees a no-op so one code never acts twice
        if (st_q.iset_alt) begin
          st_d.instr_alt = iword;
          st_d.instr_pri = INSTR_NOP;
        end else begin
          st_d.instr_pri = iword;
          st_d.instr_alt = INSTR_NOP;
        end
      end

      // data word assembles LSB first; fields split out once it is whole
      // a negative exponent is handed on as its magnitude plus a sign flag
      st_d.dshift = dword;
      if (st_q.bit_cnt == WORD_LAST_BIT) begin
        st_d.word_valid = 1'b1;
        st_d.mant = dword[MANT_LO_DIGIT*DIGIT_BITS +: MANT_DIGITS*DIGIT_BITS];
        st_d.mant_neg = dword[MANT_SIGN_DIGIT*DIGIT_BITS + MSIGN_BIT];
        st_d.dp_pos = dword[MANT_SIGN_DIGIT*DIGIT_BITS +: DP_BITS];
        st_d.exp_neg = (dword[EXP_SIGN_DIGIT*DIGIT_BITS +: DIGIT_BITS] == SIGN_NEG);
        if (dword[EXP_SIGN_DIGIT*DIGIT_BITS +: DIGIT_BITS] == SIGN_NEG) begin
          st_d.exp_mag = bcd_tens_comp(dword[EXP_LO_DIGIT*DIGIT_BITS +: EXP_DIGITS*DIGIT_BITS]);
        end else begin
          st_d.exp_mag = dword[EXP_LO_DIGIT*DIGIT_BITS +: EXP_DIGITS*DIGIT_BITS];
        end
      end

      // carry flows every bit but is kept only at the last bit of each gated run;
      // the gate's own end is seen one bit late, except at the word end
      // a window reaching digit 13 closes with the word, so no late edge
      if (gate && st_q.bit_cnt == WORD_LAST_BIT) begin
        st_d.carry       = bus.carry_line;
        st_d.carry_valid = 1'b1;
      end else if (st_q.gate_prev && !gate) begin
        st_d.carry       = st_q.carry_cand;
        st_d.carry_valid = 1'b1;
      end
      if (gate) begin
        st_d.carry_cand = bus.carry_line;
      end
      st_d.gate_prev = gate && (st_q.bit_cnt != WORD_LAST_BIT);
    end
  end

  // state register; all control state comes up cleared
  // a synchronous reset keeps a single clock domain and a clean release
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // shared lines come straight from flops, so each bit stands
  // a full bit time before the strobe that samples it
  assign bus.bit_strobe = st_q.bit_en;
  assign bus.word_sync  = st_q.word_sync;
  assign bus.dev_ws     = st_q.dev_ws;
  assign bus.iset_alt   = st_q.iset_alt;

  // user-side outputs straight from the state register
  assign instr_pri_o   = st_q.instr_pri;
  assign instr_alt_o   = st_q.instr_alt;
  assign instr_valid_o = st_q.instr_valid;
  assign carry_o       = st_q.carry;
  assign carry_valid_o = st_q.carry_valid;
  assign mant_o        = st_q.mant;
  assign mant_neg_o    = st_q.mant_neg;
  assign dp_pos_o      = st_q.dp_pos;
  assign exp_neg_o     = st_q.exp_neg;
  assign exp_mag_o     = st_q.exp_mag;
  assign word_valid_o  = st_q.word_valid;
  assign bit_cnt_o     = st_q.bit_cnt;

endmodule : ctl_timing_end

// ===== src/rom_source_end.sv
// Purpose: source end: sends instructions and a data word, may open the gate
// Assumes: bit_strobe and word_sync come from the timing end
// Notes:   a two-entry buffer holds queued instructions; one leaves per word
`timescale 1ns/1ps
module rom_source_end
  import serial_word_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  serial_word_if.source_end bus,
  input  wire logic [9:0]  instr_data_i,
  input  wire logic        instr_valid_i,
  output logic             instr_ready_o,
  input  wire logic        ws_en_i,
  input  wire logic [3:0]  ws_first_i,
  input  wire logic [3:0]  ws_last_i,
  input  wire logic        carry_i,
  input  wire logic [39:0] mant_i,
  input  wire logic        mant_neg_i,
  input  wire logic [2:0]  dp_pos_i,
  input  wire logic        exp_neg_i,
  input  wire logic [7:0]  exp_mag_i,
  output logic             iset_alt_o,
  output logic             instr_sent_o
);

  typedef struct packed {
    logic [5:0]       bit_cnt;
    logic [1:0][9:0]  mem;
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    logic [9:0]       tx_instr;
    logic [55:0]      tx_word;
    logic             ws_en;
    logic [3:0]       ws_first;
    logic [3:0]       ws_last;
    logic             rom_ws;
    logic             instr_bit;
    logic             data_bit;
    logic             carry;
    logic             sent;
  } src_state_s;

  src_state_s st_q;
  src_state_s st_d;

  // stall the user while both entries hold words not yet sent
  assign instr_ready_o = (st_q.count != IBUF_FULL);

  // next-state logic
  always_comb begin
    logic [5:0]  nxt_bit;
    logic [55:0] word;
    logic        push;
    logic        pop;
    logic [3:0]  dig;
    st_d    = st_q;
    nxt_bit = 6'h00;
    word    = '0;
    pop     = 1'b0;
    push    = instr_valid_i && instr_ready_o;
    dig     = 4'h0;
    st_d.sent = 1'b0;

    // carry is offered on every bit; the timing end chooses when to keep it
    st_d.carry = carry_i;

    if (bus.bit_strobe) begin
      // realign to the sync so digit edges match the timing end's count
      nxt_bit = bus.word_sync ? 6'h00 : st_q.bit_cnt + 6'h01;
      st_d.bit_cnt = nxt_bit;

      if (nxt_bit == 6'h00) begin
        // build the word: exponent, its sign, mantissa, sign with point
        word[EXP_LO_DIGIT*DIGIT_BITS +: EXP_DIGITS*DIGIT_BITS] =
          exp_neg_i ? bcd_tens_comp(exp_mag_i) : exp_mag_i;
        word[EXP_SIGN_DIGIT*DIGIT_BITS +: DIGIT_BITS] =
          exp_neg_i ? SIGN_NEG : SIGN_POS;
        word[MANT_LO_DIGIT*DIGIT_BITS +: MANT_DIGITS*DIGIT_BITS] = mant_i;
        word[MANT_SIGN_DIGIT*DIGIT_BITS + MSIGN_BIT] = mant_neg_i;
        word[MANT_SIGN_DIGIT*DIGIT_BITS +: DP_BITS]  = dp_pos_i;
        st_d.tx_word = word;
        // an empty buffer sends the all-low no-op
        if (st_q.count != 2'h0) begin
          pop           = 1'b1;
          st_d.tx_instr = st_q.mem[st_q.rd_ptr];
          st_d.sent     = 1'b1;
        end else begin
          st_d.tx_instr = INSTR_NOP;
        end
        st_d.ws_en    = ws_en_i;
        st_d.ws_first = ws_first_i;
        st_d.ws_last  = ws_last_i;
      end

      // drive this bit: instruction in bits 0..9, data on every bit
      st_d.instr_bit = (nxt_bit <= INSTR_LAST_BIT) ?
        st_d.tx_instr[nxt_bit[3:0]] : 1'b0;
      st_d.data_bit  = st_d.tx_word[nxt_bit];
      dig = nxt_bit[5:2];
      st_d.rom_ws = st_d.ws_en && (dig >= st_d.ws_first) &&
                    (dig <= st_d.ws_last) && (dig <= LAST_DIGIT);
    end

    // buffer bookkeeping; push and pop may meet in one cycle
    if (push) begin
      st_d.mem[st_q.wr_ptr] = instr_data_i;
      st_d.wr_ptr = ~st_q.wr_ptr;
    end
    if (pop) begin
      st_d.rd_ptr = ~st_q.rd_ptr;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 2'h1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.rom_ws                  = st_q.rom_ws;
  assign bus.serial_instruction_line = st_q.instr_bit;
  assign bus.data_line               = st_q.data_bit;
  assign bus.carry_line              = st_q.carry;
  assign iset_alt_o                  = bus.iset_alt;
  assign instr_sent_o                = st_q.sent;

endmodule : rom_source_end

// ===== verif/serial_word_bus_timing_assertions.sv
// Purpose: concurrent checks on the shared serial word lines
// Assumes: one clock, synchronous active-low reset
// Notes:   bit_pos_q follows the bit now standing on the lines
`timescale 1ns/1ps
module serial_word_bus_timing_assertions
  import serial_word_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic bit_strobe,
  input wire logic word_sync,
  input wire logic dev_ws,
  input wire logic word_select_gate,
  input wire logic serial_instruction_line,
  input wire logic data_line,
  input wire logic iset_alt
);
  logic [5:0] bit_pos_q;
  logic [5:0] bit_pos_d;

  // own bit count, restarted by the sync strobe so a slip shows up
  always_comb begin
    bit_pos_d = bit_pos_q;
    if (bit_strobe) begin
      bit_pos_d = word_sync ? 6'h00 : bit_pos_q + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bit_pos_q <= 6'h00;
    end else begin
      bit_pos_q <= bit_pos_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_strobe_period: assert property (bit_strobe |=> !bit_strobe [*4] ##1 bit_strobe)
    else $error("bit strobe not every five clocks");
  chk_sync_width: assert property ($rose(word_sync) |-> word_sync [*5] ##1 !word_sync)
    else $error("word sync not one bit time wide");
  chk_sync_count: assert property (bit_strobe |-> word_sync == (bit_pos_q == WORD_LAST_BIT))
    else $error("word sync not on bit 55");
  chk_dev_ws_digit: assert property ($changed(dev_ws) |-> $past(bit_strobe) && bit_pos_q[1:0] == 2'h0)
    else $error("timing end gate moved inside a digit");
  chk_gate_digit: assert property ($changed(word_select_gate) |-> bit_pos_q[1:0] == 2'h0)
    else $error("gate moved inside a digit");
  chk_instr_tail: assert property (bit_pos_q > INSTR_LAST_BIT |-> !serial_instruction_line)
    else $error("instruction line high past bit 9");
  chk_line_hold: assert property (!$past(bit_strobe) |-> $stable(data_line) && $stable(serial_instruction_line))
    else $error("line changed inside a bit time");
  chk_iset_word: assert property ($changed(iset_alt) |-> $past(bit_strobe && word_sync))
    else $error("instruction set changed inside a word");
  chk_sign_code: assert property (bit_strobe && (bit_pos_q == 6'h09 || bit_pos_q == 6'h0A) |-> !data_line)
    else $error("exponent sign digit neither 0 nor 9");
endmodule : serial_word_bus_timing_assertions

// ===== verif/serial_word_bus_timing_bench.sv
// Purpose: drives both ends of the serial word bus and checks every second word, then three words in a row
// Assumes: 25 MHz clock, inputs changed on the falling edge
// Notes:   settings change mid-word and take effect at the next word start
`timescale 1ns/1ps
module serial_word_bus_timing_bench;
  import serial_word_pkg::*;
  logic        clk_i, rstn_i, iset_alt_i, c_en, r_en, carry_i, instr_valid_i, cv_seen;
  logic        mant_neg_i, exp_neg_i, mant_neg_o, exp_neg_o, instr_ready_o, iset_alt_o;
  logic        carry_o, carry_valid_o, word_valid_o;
  logic        iv_seen, sent_w, instr_valid_o, instr_sent_o;
  logic [9:0]  iq[$];  // accepted instructions not yet checked on the line
  logic [3:0]  c_first, c_last, r_first, r_last;
  logic [9:0]  instr_data_i, instr_pri_o, instr_alt_o, v;
  logic [39:0] mant_i, mant_o;
  logic [2:0]  dp_pos_i, dp_pos_o;
  logic [7:0]  exp_mag_i, exp_mag_o;
  logic [5:0]  bit_cnt_o;
  logic [55:0] data_w, instr_w, gate_w, carry_w;
  int          failures, checks_done;

  serial_word_if bus ();
  ctl_timing_end ctl_timing_end_i (.clk_i, .rstn_i, .bus(bus), .iset_alt_i, .ws_en_i(c_en),
    .ws_first_i(c_first), .ws_last_i(c_last), .instr_pri_o, .instr_alt_o, .instr_valid_o,
    .carry_o, .carry_valid_o, .mant_o, .mant_neg_o, .dp_pos_o, .exp_neg_o, .exp_mag_o,
    .word_valid_o, .bit_cnt_o);
  rom_source_end rom_source_end_i (.clk_i, .rstn_i, .bus(bus), .instr_data_i, .instr_valid_i,
    .instr_ready_o, .ws_en_i(r_en), .ws_first_i(r_first), .ws_last_i(r_last), .carry_i,
    .mant_i, .mant_neg_i, .dp_pos_i, .exp_neg_i, .exp_mag_i, .iset_alt_o, .instr_sent_o);
  serial_word_bus_timing_assertions serial_word_bus_timing_assertions_i (.clk_i, .rstn_i,
    .bit_strobe(bus.bit_strobe), .word_sync(bus.word_sync), .dev_ws(bus.dev_ws),
    .word_select_gate(bus.word_select_gate), .data_line(bus.data_line),
    .serial_instruction_line(bus.serial_instruction_line), .iset_alt(bus.iset_alt));

  // 40 ns clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // carry wanders every cycle, as the arithmetic side sends it all the time
  always @(negedge clk_i) carry_i <= 1'($urandom);

  // record every sampled bit; carry pulses are collected per word
  always @(posedge clk_i) begin
    if (bus.bit_strobe) begin
      data_w[bit_cnt_o]  <= bus.data_line;
      instr_w[bit_cnt_o] <= bus.serial_instruction_line;
      gate_w[bit_cnt_o]  <= bus.word_select_gate;
      carry_w[bit_cnt_o] <= bus.carry_line;
    end
    if (bus.bit_strobe && bit_cnt_o == 6'h00) cv_seen <= 1'b0;
    else if (carry_valid_o) cv_seen <= 1'b1;
    if (bus.bit_strobe && bit_cnt_o == 6'h00) iv_seen <= 1'b0;
    else if (instr_valid_o) iv_seen <= 1'b1;
    // a load marks the word it starts and wins over the word before's end in the same cycle; that word's own end clears it
    if (instr_sent_o) sent_w <= 1'b1;
    else if (word_valid_o) sent_w <= 1'b0;
  end

  task give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // bounded wait for word end or for a given bit index
  task wait_until(input bit wv, input logic [5:0] b);
    for (int k = 0; k < 400; k++) begin
      if (wv ? word_valid_o === 1'b1 : bit_cnt_o === b) return;
      @(negedge clk_i);
    end
    failures++;
    give_verdict();
  endtask : wait_until

  // valid is left high so a second push can follow at once; the model queues it
  task push(input logic [9:0] d);
    instr_data_i  = d;
    instr_valid_i = 1'b1;
    for (int k = 0; k < 400 && instr_ready_o !== 1'b1; k++) @(negedge clk_i);
    if (instr_ready_o !== 1'b1) begin
      failures++;
      give_verdict();
    end
    iq.push_back(d);
    @(negedge clk_i);
  endtask : push

  // reference model of the next whole word, compared once it has been received
  task word_check(input logic [9:0] ei);
    logic [55:0] e;
    logic [55:0] g;
    logic [9:0]  qi;
    int          m;
    int          last;
    wait_until(0, 6'h00);
    @(negedge clk_i);
    wait_until(1, 6'h00);
    // an empty buffer sends the no-op; otherwise the oldest accepted word
    qi = (iq.size() != 0) ? iq.pop_front() : INSTR_NOP;
    m = exp_mag_i[7:4] * 10 + exp_mag_i[3:0];
    if (exp_neg_i && m != 0) m = 100 - m;
    e = {mant_neg_i, dp_pos_i, mant_i, exp_neg_i ? 4'h9 : 4'h0, 4'(m / 10), 4'(m % 10)};
    last = -1;
    for (int d = 0; d < WORD_DIGITS; d++) begin
      g[4*d +: 4] = {4{(c_en && c_first <= d && d <= c_last) ||
                       (r_en && r_first <= d && d <= r_last)}};
      if (g[4*d]) last = 4 * d + 3;
    end
    chk("data_line", data_w, e);
    chk("gate", gate_w, g);
    chk("instr_line", instr_w, {46'h0, qi});
    chk("instr_pri", instr_pri_o, iset_alt_i ? 10'h000 : qi);
    chk("instr_alt", instr_alt_o, iset_alt_i ? qi : 10'h000);
    chk("instr_scen", instr_pri_o | instr_alt_o, ei);
    chk("instr_valid", iv_seen, 1'b1);
    chk("instr_sent", sent_w, qi != INSTR_NOP);
    chk("iset_copy", iset_alt_o, iset_alt_i);
    chk("fields", {mant_o, mant_neg_o, dp_pos_o, exp_neg_o, exp_mag_o},
        {mant_i, mant_neg_i, dp_pos_i, exp_neg_i, exp_mag_i});
    chk("carry_seen", cv_seen | carry_valid_o, last >= 0);
    if (last >= 0) chk("carry", carry_o, carry_w[last]);
  endtask : word_check

  // random words, then a full buffer with one refused push
  initial begin
    void'($urandom(41));
    {rstn_i, iset_alt_i, c_en, r_en, instr_valid_i, mant_neg_i, exp_neg_i} = 7'h00;
    {c_first, c_last, r_first, r_last, dp_pos_i, exp_mag_i} = 27'h0;
    {instr_data_i, mant_i} = 50'h0;
    failures    = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    for (int it = 0; it < 16; it++) begin
      wait_until(0, 6'h14);
      for (int d = 0; d < 10; d++) mant_i[4*d +: 4] = 4'($urandom % 10);
      {mant_neg_i, dp_pos_i, exp_neg_i, iset_alt_i, c_en, r_en} = 8'($urandom);
      exp_mag_i = {4'($urandom % 10), 4'($urandom % 10)};
      {c_first, c_last, r_first, r_last} = 16'($urandom);
      v = 10'($urandom) | 10'h001;
      if (it == 0) begin
        {c_en, c_first, c_last, r_en, exp_neg_i, exp_mag_i} = {1'b1, 8'h0D, 2'h1, 8'h00};
      end
      if (it == 1) begin
        {c_en, r_en, v} = 12'h000;
      end
      if (v != 10'h000) push(v);
      instr_valid_i = 1'b0;
      word_check(v);
    end
    wait_until(0, 6'h14);
    push(10'h2A5);
    push(10'h15A);
    chk("ready_full", instr_ready_o, 1'b0);
    instr_data_i = 10'h3C3;
    repeat (3) @(negedge clk_i);
    instr_valid_i = 1'b0;
    word_check(10'h2A5);
    word_check(10'h15A);
    word_check(10'h000);
    give_verdict();
  end
endmodule : serial_word_bus_timing_bench
